// [eac_ctrl.sv]
// data nonvolatile memory access control: registers, read and write sequencing, interrupt
`timescale 1ns/1ps

// Behaviour
// - writes to the array start only if write_enable_bit is already one
// - reads from the array start only if read_enable_bit is already one
// - setting read-start begins a read; hardware clears it when the read ends
// - read-start with read_enable_bit low starts nothing, but the same write still loads both enable bits from the byte
// - after read-start clears, the fetched byte is in the data register
// - data register keeps the last byte until another read runs or the core writes it while idle
// - write-start with write_enable_bit low starts no write
// - write time is set by a timer independent of the request timing
// - hardware clears write-start when the write ends
// - write_enable_bit is cleared at reset
// - pointer high byte resets to zero; control register needs sector one
// - every finished write sets the interrupt request flag
// - branch only when flag, both enables set and stack not full
// - servicing the interrupt clears the flag and the global enable
// - address register seven bits wide, data register eight bits
module eac_ctrl
	import eac_pkg::*;
#(
	parameter int p_wr_time_us = eac_pkg::c_wr_time_us
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_srst,
	// data memory port of the core
	input wire logic [7:0] i_addr,
	input wire logic i_ind,
	input wire logic i_we,
	input wire logic i_re,
	input wire logic [7:0] i_wdata,
	output logic [7:0] o_rdata,
	// interrupt controller side
	input wire logic i_stack_full,
	input wire logic i_irq_ack,
	output logic o_int_branch,
	// cell array side
	input wire logic [eac_pkg::c_data_w-1:0] i_arr_rdata,
	output logic o_arr_rd,
	output logic o_arr_wr,
	output logic [eac_pkg::c_addr_w-1:0] o_arr_addr,
	output logic [eac_pkg::c_data_w-1:0] o_arr_wdata
);
	import eac_pkg::*;

	// ****************************************
	// state
	// ****************************************
	typedef struct packed {
		eac_state_t st;
		logic [c_addr_w-1:0] addr;
		logic [c_data_w-1:0] data;
		logic [7:0] ptr1h;
		logic write_enable_bit;
		logic read_enable_bit;
		logic rd;
		logic wr;
		logic gie;
		logic nvie;
		logic nvif;
		logic [7:0] rdata;
		logic branch;
		logic rd_go;
		logic wr_go;
		logic arr_rd;
		logic arr_wr;
	} eac_regs_t;

	localparam logic [c_tmr_w-1:0] c_wr_ticks = c_tmr_w'(p_wr_time_us);
	localparam logic [c_tmr_w-1:0] c_rd_ticks = c_tmr_w'(c_rd_cycles);
	localparam int c_rd_bound = 8;

	eac_regs_t q_r;
	eac_regs_t q_nxt;
	logic tick;
	logic rd_done;
	logic wr_done;
	logic ctrl_sel;
	logic ctrl_hit;
	logic idle;
	logic want_rd;
	logic want_wr;
	logic [7:0] ctrl_byte;
	logic [7:0] intc_byte;

	// ****************************************
	// timers
	// ****************************************
	eac_tick_div #(.DIV(c_tick_div)) u_div (
		.i_clk(i_clk),
		.i_srst(i_srst),
		.o_tick(tick)
	);

	eac_cycle_timer #(.W(c_tmr_w)) u_rd_tmr (
		.i_clk(i_clk),
		.i_srst(i_srst),
		.i_start(q_r.rd_go),
		.i_tick(1'b1),
		.i_count(c_rd_ticks),
		.o_busy(),
		.o_done(rd_done)
	);

	// write duration counts divider ticks whose phase is unrelated to the start
	eac_cycle_timer #(.W(c_tmr_w)) u_wr_tmr (
		.i_clk(i_clk),
		.i_srst(i_srst),
		.i_start(q_r.wr_go),
		.i_tick(tick),
		.i_count(c_wr_ticks),
		.o_busy(),
		.o_done(wr_done)
	);

	// ****************************************
	// next state
	// ****************************************
	always_comb begin
		q_nxt = q_r;
		q_nxt.rd_go = 1'b0;
		q_nxt.wr_go = 1'b0;
		q_nxt.branch = 1'b0;
		idle = (q_r.st == ST_IDLE);
		// control register only visible through pointer 1 in sector one
		ctrl_sel = i_ind && (q_r.ptr1h == c_sector_ctrl) && (i_addr == c_off_ctrl);
		ctrl_hit = i_we && ctrl_sel;
		ctrl_byte = {4'h0, q_r.write_enable_bit, q_r.wr, q_r.read_enable_bit, q_r.rd};
		intc_byte = {5'h00, q_r.nvif, q_r.nvie, q_r.gie};
		// starts use the enable already stored, so enable and start cannot share a write
		want_rd = ctrl_hit && i_wdata[c_bit_rd] && q_r.read_enable_bit && !i_wdata[c_bit_wr];
		want_wr = ctrl_hit && i_wdata[c_bit_wr] && q_r.write_enable_bit && !i_wdata[c_bit_rd];

		// register writes
		if (i_we && !i_ind) begin
			// address and data are held steady while the array is busy
			if (i_addr == c_off_addr && idle) begin
				q_nxt.addr = i_wdata[c_addr_w-1:0];
			end
			if (i_addr == c_off_data && idle) begin
				q_nxt.data = i_wdata;
			end
			if (i_addr == c_off_ptr1h) begin
				q_nxt.ptr1h = i_wdata;
			end
			if (i_addr == c_off_intc) begin
				q_nxt.gie = i_wdata[c_bit_gie];
				q_nxt.nvie = i_wdata[c_bit_nvie];
				q_nxt.nvif = i_wdata[c_bit_nvif];
			end
		end
		if (ctrl_hit) begin
			q_nxt.write_enable_bit = i_wdata[c_bit_write_enable_bit];
			q_nxt.read_enable_bit = i_wdata[c_bit_read_enable_bit];
		end

		// sequencer
		case (q_r.st)
			ST_IDLE: begin
				if (want_rd) begin
					q_nxt.st = ST_READ;
					q_nxt.rd = 1'b1;
					q_nxt.rd_go = 1'b1;
					q_nxt.arr_rd = 1'b1;
				end else if (want_wr) begin
					q_nxt.st = ST_WRITE;
					q_nxt.wr = 1'b1;
					q_nxt.wr_go = 1'b1;
					q_nxt.arr_wr = 1'b1;
				end
			end
			// start requests fall through untouched while a cycle runs
			ST_READ: begin
				q_nxt.arr_rd = 1'b0;
				if (rd_done) begin
					q_nxt.st = ST_IDLE;
					q_nxt.rd = 1'b0;
					q_nxt.data = i_arr_rdata;
				end
			end
			ST_WRITE: begin
				if (wr_done) begin
					q_nxt.st = ST_IDLE;
					q_nxt.wr = 1'b0;
					q_nxt.arr_wr = 1'b0;
				end
			end
			default: begin
				q_nxt.st = ST_IDLE;
				q_nxt.rd = 1'b0;
				q_nxt.wr = 1'b0;
				q_nxt.arr_rd = 1'b0;
				q_nxt.arr_wr = 1'b0;
			end
		endcase

		// interrupt: service clears flag and global enable, a new write end still wins
		if (i_irq_ack) begin
			q_nxt.nvif = 1'b0;
			q_nxt.gie = 1'b0;
		end
		if (q_r.st == ST_WRITE && wr_done) begin
			q_nxt.nvif = 1'b1;
		end
		q_nxt.branch = q_r.nvif && q_r.gie && q_r.nvie && !i_stack_full && !i_irq_ack;

		// read port
		if (i_re) begin
			if (ctrl_sel) begin
				q_nxt.rdata = ctrl_byte;
			end else if (i_ind) begin
				q_nxt.rdata = c_byte_zero;
			end else if (i_addr == c_off_addr) begin
				q_nxt.rdata = {1'b0, q_r.addr};
			end else if (i_addr == c_off_data) begin
				q_nxt.rdata = q_r.data;
			end else if (i_addr == c_off_ptr1h) begin
				q_nxt.rdata = q_r.ptr1h;
			end else if (i_addr == c_off_intc) begin
				q_nxt.rdata = intc_byte;
			end else begin
				q_nxt.rdata = c_byte_zero;
			end
		end
	end

	// ****************************************
	// registers
	// ****************************************
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			q_r <= '0;
			q_r.st <= ST_IDLE;
			q_r.addr <= c_addr_rst;
			q_r.data <= c_data_rst;
			q_r.ptr1h <= c_ptr_rst;
			q_r.write_enable_bit <= 1'b0;
		end else begin
			q_r <= q_nxt;
		end
	end

	assign o_rdata = q_r.rdata;
	assign o_int_branch = q_r.branch;
	assign o_arr_rd = q_r.arr_rd;
	assign o_arr_wr = q_r.arr_wr;
	assign o_arr_addr = q_r.addr;
	assign o_arr_wdata = q_r.data;

	// ****************************************
	// checks
	// ****************************************
	a_wr_needs_en: assert property (@(posedge i_clk) disable iff (i_srst)
		$rose(q_r.wr) |-> $past(q_r.write_enable_bit) && o_arr_wr)
		else $error("write started without write enable");

	a_rd_needs_en: assert property (@(posedge i_clk) disable iff (i_srst)
		$rose(q_r.rd) |-> $past(q_r.read_enable_bit) && o_arr_rd)
		else $error("read started without read enable");

	a_rd_clears: assert property (@(posedge i_clk) disable iff (i_srst)
		$rose(q_r.rd) |-> ##[1:c_rd_bound] !q_r.rd)
		else $error("read start bit not cleared in time");

	a_rd_data: assert property (@(posedge i_clk) disable iff (i_srst)
		$fell(q_r.rd) |-> q_r.data == $past(i_arr_rdata))
		else $error("fetched byte not in data register");

	a_data_hold: assert property (@(posedge i_clk) disable iff (i_srst)
		(q_r.st == ST_WRITE) |=> $stable(q_r.data))
		else $error("data register changed during a write");

	a_wr_end_flag: assert property (@(posedge i_clk) disable iff (i_srst)
		$fell(q_r.wr) |-> q_r.nvif && q_r.st == ST_IDLE && !o_arr_wr)
		else $error("write end did not raise the flag");

	a_branch_cause: assert property (@(posedge i_clk) disable iff (i_srst)
		o_int_branch |-> $past(q_r.nvif && q_r.gie && q_r.nvie && !i_stack_full))
		else $error("branch without all conditions");

	a_ack_clears: assert property (@(posedge i_clk) disable iff (i_srst)
		i_irq_ack |=> !q_r.gie)
		else $error("service left global enable set");

	a_busy_ignore: assert property (@(posedge i_clk) disable iff (i_srst)
		(q_r.st != ST_IDLE) |=> !(q_r.rd && q_r.wr))
		else $error("second start taken while busy");

	a_busy_hold: assert property (@(posedge i_clk) disable iff (i_srst)
		(q_r.st != ST_IDLE && ctrl_hit) |=> $stable(q_r.st) || $past(rd_done || wr_done))
		else $error("start taken while a cycle runs");

	a_ctrl_gated: assert property (@(posedge i_clk) disable iff (i_srst)
		(q_r.ptr1h != c_sector_ctrl && q_r.st == ST_IDLE) |=> !$rose(q_r.write_enable_bit))
		else $error("control register reached outside sector one");

	a_reset_vals: assert property (@(posedge i_clk) disable iff (i_srst)
		$past(i_srst) |-> !q_r.write_enable_bit && q_r.ptr1h == c_ptr_rst)
		else $error("reset values wrong");
endmodule : eac_ctrl

// [eac_pkg.sv]
// constants shared by the data nonvolatile access control block
package eac_pkg;
	// data memory offsets of the block's registers
	localparam logic [7:0] c_off_addr = 8'h1E;
	localparam logic [7:0] c_off_data = 8'h1F;
	localparam logic [7:0] c_off_ptr1h = 8'h03;
	localparam logic [7:0] c_off_intc = 8'h0E;
	localparam logic [7:0] c_off_ctrl = 8'h40;
	localparam logic [7:0] c_sector_ctrl = 8'h01;
	localparam logic [7:0] c_ptr_rst = 8'h00;
	// widths
	localparam int c_addr_w = 7;
	localparam int c_data_w = 8;
	localparam int c_tmr_w = 16;
	// control register fields
	localparam int c_bit_rd = 0;
	localparam int c_bit_read_enable_bit = 1;
	localparam int c_bit_wr = 2;
	localparam int c_bit_write_enable_bit = 3;
	// interrupt control register fields
	localparam int c_bit_gie = 0;
	localparam int c_bit_nvie = 1;
	localparam int c_bit_nvif = 2;
	localparam logic [7:0] c_byte_zero = 8'h00;
	localparam logic [c_addr_w-1:0] c_addr_rst = 7'h00;
	localparam logic [c_data_w-1:0] c_data_rst = 8'h00;
	// timing
	localparam int c_clk_hz = 20_000_000;
	localparam int c_us_per_s = 1_000_000;
	localparam int c_tick_div = c_clk_hz / c_us_per_s;
	localparam int c_wr_time_us = 2000;
	localparam int c_rd_cycles = 4;
	// sequencer states
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_READ = 3'b010,
		ST_WRITE = 3'b100
	} eac_state_t;
endpackage : eac_pkg

// [eac_tick_div.sv]
// free-running divider giving a one-cycle tick for the write timer
`timescale 1ns/1ps
module eac_tick_div #(
	parameter int DIV = 20
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_srst,
	// tick
	output logic o_tick
);
	typedef struct packed {
		logic [7:0] cnt;
		logic tick;
	} eac_div_t;
	localparam logic [7:0] c_last = 8'(DIV - 1);
	localparam logic [7:0] c_one = 8'h01;
	eac_div_t q_r;
	eac_div_t q_nxt;

	// the phase never resets on a request, so write time varies like a separate oscillator
	always_comb begin
		q_nxt = q_r;
		q_nxt.tick = (q_r.cnt == c_last);
		q_nxt.cnt = q_nxt.tick ? 8'h00 : q_r.cnt + c_one;
	end

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			q_r <= '0;
		end else begin
			q_r <= q_nxt;
		end
	end

	assign o_tick = q_r.tick;

	a_tick_single: assert property (@(posedge i_clk) disable iff (i_srst)
		o_tick |=> !o_tick) else $error("divider tick lasted more than one cycle");
endmodule : eac_tick_div

// [eac_cycle_timer.sv]
// counts a number of enable ticks after a start pulse, then pulses done
`timescale 1ns/1ps
module eac_cycle_timer #(
	parameter int W = 16
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_srst,
	// control
	input wire logic i_start,
	input wire logic i_tick,
	input wire logic [W-1:0] i_count,
	// status
	output logic o_busy,
	output logic o_done
);
	typedef struct packed {
		logic [W-1:0] cnt;
		logic busy;
		logic done;
	} eac_tmr_t;
	localparam logic [W-1:0] c_one = W'(1);
	eac_tmr_t q_r;
	eac_tmr_t q_nxt;

	always_comb begin
		q_nxt = q_r;
		q_nxt.done = 1'b0;
		if (i_start && !q_r.busy) begin
			q_nxt.busy = 1'b1;
			q_nxt.cnt = i_count;
		end else if (q_r.busy && i_tick) begin
			if (q_r.cnt <= c_one) begin
				q_nxt.busy = 1'b0;
				q_nxt.done = 1'b1;
			end else begin
				q_nxt.cnt = q_r.cnt - c_one;
			end
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			q_r <= '0;
		end else begin
			q_r <= q_nxt;
		end
	end

	assign o_busy = q_r.busy;
	assign o_done = q_r.done;

	a_done_ends_busy: assert property (@(posedge i_clk) disable iff (i_srst)
		o_done |-> !o_busy && $past(o_busy)) else $error("timer done without a run");
endmodule : eac_cycle_timer

// [eac_array_model.sv]
// stand-in for the cell array: answers read pulses and stores finished writes
`timescale 1ns/1ps
module eac_array_model (
	// clock
	input wire logic i_clk,
	// array port
	input wire logic i_rd,
	input wire logic i_wr,
	input wire logic [6:0] i_addr,
	input wire logic [7:0] i_wdata,
	output logic [7:0] o_rdata
);
	logic [7:0] mem [128];
	logic [7:0] hold_r = 8'h00;
	logic [2:0] left_r = 3'h0;
	logic wr_q = 1'b0;
	initial begin
		for (int i = 0; i < 128; i++) begin
			mem[i] = 8'(i) ^ 8'hA5;
		end
	end
	always @(posedge i_clk) begin
		wr_q <= i_wr;
		// cell is only updated once the timed cycle is over
		if (wr_q && !i_wr) begin
			mem[i_addr] <= i_wdata;
		end
		if (i_rd) begin
			hold_r <= mem[i_addr];
			left_r <= 3'h6;
		end else if (left_r != 3'h0) begin
			left_r <= left_r - 3'h1;
		end
	end
	// after the hold window the byte flips, so a late sample cannot pass
	assign o_rdata = (left_r != 3'h0) ? hold_r : ~hold_r;
endmodule : eac_array_model

// [test_eac_ctrl.sv]
// self-checking bench for the nonvolatile access control block
`timescale 1ns/1ps
module test_eac_ctrl;
	import eac_pkg::*;
	logic i_clk, i_srst, i_ind, i_we, i_re, i_stack_full, i_irq_ack;
	logic [7:0] i_addr, i_wdata, o_rdata;
	logic o_int_branch, o_arr_rd, o_arr_wr;
	logic [c_data_w-1:0] i_arr_rdata, o_arr_wdata;
	logic [c_addr_w-1:0] o_arr_addr;
	logic [8:0] exp_q[$];
	logic [8:0] e;
	logic re_seen = 1'b0;
	logic [6:0] aa[3];
	logic [7:0] dd[3];
	int mismatches, total_checks, n;

	eac_ctrl #(.p_wr_time_us(3)) u_dut (
		.i_clk(i_clk), .i_srst(i_srst), .i_addr(i_addr), .i_ind(i_ind), .i_we(i_we),
		.i_re(i_re), .i_wdata(i_wdata), .o_rdata(o_rdata), .i_stack_full(i_stack_full),
		.i_irq_ack(i_irq_ack), .o_int_branch(o_int_branch), .i_arr_rdata(i_arr_rdata),
		.o_arr_rd(o_arr_rd), .o_arr_wr(o_arr_wr), .o_arr_addr(o_arr_addr),
		.o_arr_wdata(o_arr_wdata));
	eac_array_model u_arr (.i_clk(i_clk), .i_rd(o_arr_rd), .i_wr(o_arr_wr),
		.i_addr(o_arr_addr), .i_wdata(o_arr_wdata), .o_rdata(i_arr_rdata));

	initial begin
		i_clk = 1'b0;
		forever #25 i_clk = ~i_clk;
	end

	// ****************************************
	// compare, verdict and bus tasks
	// ****************************************
	task automatic chk(input string what, input logic [7:0] ex, input logic [7:0] g);
		total_checks++;
		if (g !== ex) begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", what, ex, g);
		end
	endtask : chk
	task automatic chk_flag(input string what, input logic ex, input logic g);
		total_checks++;
		if (g !== ex) begin
			mismatches++;
			$display("wrong value %s expected %b seen %b", what, ex, g);
		end
	endtask : chk_flag
	task automatic results();
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : results
	// every request is held for exactly one rising edge
	task automatic bus(input logic we, re, ind, input logic [7:0] a, d);
		i_we = we;
		i_re = re;
		i_ind = ind;
		i_addr = a;
		i_wdata = d;
		@(negedge i_clk);
	endtask : bus
	task automatic wr(input logic [7:0] a, d);
		bus(1'b1, 1'b0, 1'b0, a, d);
	endtask : wr
	task automatic wc(input logic [7:0] d);
		bus(1'b1, 1'b0, 1'b1, c_off_ctrl, d);
	endtask : wc
	task automatic idle();
		bus(1'b0, 1'b0, 1'b0, 8'h00, 8'h00);
	endtask : idle
	task automatic rd(input logic ind, input logic [7:0] a, ex, input bit on = 1'b1);
		exp_q.push_back({on, ex});
		bus(1'b0, 1'b1, ind, a, 8'h00);
	endtask : rd
	// polls a control bit until hardware drops it; n counts the cycles spent
	task automatic poll(input int b, output int cnt);
		cnt = 0;
		do begin
			rd(1'b1, c_off_ctrl, 8'h00, 1'b0);
			cnt++;
		end while (o_rdata[b] === 1'b1 && cnt < 200);
	endtask : poll

	// ****************************************
	// result watcher
	// ****************************************
	always @(posedge i_clk) re_seen <= i_re && !i_srst;
	always @(negedge i_clk) begin
		if (re_seen && exp_q.size() > 0) begin
			e = exp_q.pop_front();
			if (e[8]) begin
				chk("register read", e[7:0], o_rdata);
			end
		end
	end

	initial begin
		repeat (5000) @(posedge i_clk);
		mismatches++;
		results();
	end

	// ****************************************
	// scenarios
	// ****************************************
	initial begin
		i_srst = 1'b1;
		i_stack_full = 1'b1;
		i_irq_ack = 1'b0;
		mismatches = 0;
		total_checks = 0;
		void'($urandom(32'h60c3c8a2));
		idle();
		idle();
		i_srst = 1'b0;
		rd(1'b0, c_off_addr, 8'h00);
		rd(1'b0, c_off_ptr1h, c_ptr_rst);
		rd(1'b0, c_off_intc, 8'h00);
		wc(8'h0A);
		wr(c_off_ptr1h, c_sector_ctrl);
		rd(1'b1, c_off_ctrl, 8'h00);
		wc(8'h01);
		chk_flag("read strobe without enable", 1'b0, o_arr_rd);
		wc(8'h04);
		chk_flag("write strobe without enable", 1'b0, o_arr_wr);
		rd(1'b1, c_off_ctrl, 8'h00);
		rd(1'b0, c_off_data, 8'h00);
		wr(c_off_addr, 8'hFF);
		rd(1'b0, c_off_addr, 8'h7F);
		for (int i = 0; i < 3; i++) begin
			aa[i] = {i[1:0], 5'($urandom)};
			dd[i] = 8'($urandom);
			wr(c_off_addr, {1'b0, aa[i]});
			wr(c_off_data, dd[i]);
			// global enable stays off while arming
			wr(c_off_intc, 8'h02);
			wc(8'h08);
			wc(8'h0C);
			wr(c_off_intc, 8'h03);
			wr(c_off_addr, 8'h00);
			// a second start while the write runs must not restart it
			wc(8'h0C);
			chk_flag("array write strobe", 1'b1, o_arr_wr);
			chk("array address", {1'b0, aa[i]}, {1'b0, o_arr_addr});
			chk("array data", dd[i], o_arr_wdata);
			poll(c_bit_wr, n);
			chk_flag("write time", 1'b1, n >= 35 && n <= 70);
			chk_flag("array write end", 1'b0, o_arr_wr);
			rd(1'b0, c_off_addr, {1'b0, aa[i]});
			rd(1'b0, c_off_intc, 8'h07);
			chk_flag("branch with stack full", 1'b0, o_int_branch);
			i_stack_full = 1'b0;
			idle();
			idle();
			chk_flag("branch", 1'b1, o_int_branch);
			i_irq_ack = 1'b1;
			idle();
			i_irq_ack = 1'b0;
			i_stack_full = 1'b1;
			rd(1'b0, c_off_intc, 8'h02);
		end
		for (int i = 0; i < 3; i++) begin
			wr(c_off_addr, {1'b0, aa[i]});
			wc(8'h02);
			wc(8'h03);
			chk_flag("array read strobe", 1'b1, o_arr_rd);
			poll(c_bit_rd, n);
			chk_flag("read time", 1'b1, n <= 8);
			rd(1'b0, c_off_data, dd[i]);
		end
		wr(c_off_addr, 8'h00);
		rd(1'b1, c_off_ctrl, 8'h02);
		rd(1'b0, c_off_data, dd[2]);
		wc(8'h0A);
		wc(8'h0F);
		chk_flag("read strobe on double start", 1'b0, o_arr_rd);
		chk_flag("write strobe on double start", 1'b0, o_arr_wr);
		rd(1'b1, c_off_ctrl, 8'h0A);
		wc(8'h00);
		idle();
		idle();
		results();
	end
endmodule : test_eac_ctrl
